// *** design/mpc_regs.sv ***
// file: mic preamp control register bank, top level
//==========================================================================
// Overview of operation
// - left preamp enable at two addresses
// - right preamp enable at two addresses
// - each preamp enable is one shared flop
// - left pin connects bits 0..2, reset 1,1,0
// - right pin connects bits 8..10, reset 1,1,0
// - left gain bits 7:2, reset 0 dB
// - right gain bits 7:2, reset 0 dB
// - update bit releases both pending gains together
// - zero-cross bit chooses immediate or crossing apply
// - mute bit silences channel; pin connects stay as set
// - one gain covers all selected pins
// - bias enable at two addresses, off is hi-z
// - bias enable is one shared flop
// - bias level select 0.9 or 0.75 supply
// - registers held reset until master enable set
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module mpc_regs (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic left_zero_cross,
  input wire logic right_zero_cross,
  output mpc_pkg::mpc_drive_t left_drive,
  output mpc_pkg::mpc_drive_t right_drive,
  output logic mic_bias_output_oe_n,
  output logic mic_bias_level_select,
  output logic master_codec_on,
  output logic left_gain_waiting,
  output logic right_gain_waiting
);

  // =====================================================================
  // decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  logic master_codec_on_ff;
  logic hold_reset;
  mpc_pkg::mpc_chan_t left_ff;
  mpc_pkg::mpc_chan_t right_ff;
  logic left_first_pos_pin_connect_ff;
  logic left_neg_pin_connect_ff;
  logic left_second_pos_pin_connect_ff;
  logic right_first_pos_pin_connect_ff;
  logic right_neg_pin_connect_ff;
  logic right_second_pos_pin_connect_ff;
  logic mic_bias_on_ff;
  logic mic_bias_level_select_ff;
  logic gain_update_strobe;
  logic wr_p1;
  logic wr_p2;
  logic wr_p5;
  logic wr_pins;
  logic wr_bias;
  logic wr_left;
  logic wr_right;
  logic [15:0] nxt_rdata;
  logic [15:0] rdata_ff;
  logic [5:0] left_gain;
  logic [5:0] right_gain;

  assign wr_p1 = reg_wr && hit(reg_addr, mpc_pkg::ADDR_POWER_ONE);
  assign wr_p2 = reg_wr && hit(reg_addr, mpc_pkg::ADDR_POWER_TWO);
  assign wr_p5 = reg_wr && hit(reg_addr, mpc_pkg::ADDR_POWER_FIVE);
  assign wr_pins = reg_wr && hit(reg_addr, mpc_pkg::ADDR_PIN_SELECT);
  assign wr_bias = reg_wr && hit(reg_addr, mpc_pkg::ADDR_BIAS_CONTROL);
  assign wr_left = reg_wr && hit(reg_addr, mpc_pkg::ADDR_LEFT_GAIN);
  assign wr_right = reg_wr && hit(reg_addr, mpc_pkg::ADDR_RIGHT_GAIN);

  // =====================================================================
  // master enable, itself outside the held group
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      master_codec_on_ff <= 1'b0;
    end else if (wr_p5) begin
      master_codec_on_ff <= reg_wdata[mpc_pkg::BIT_MASTER_ON];
    end
  end

  // writes while held are dropped, not deferred
  assign hold_reset = !master_codec_on_ff;

  // =====================================================================
  // preamp enables, one flop each behind two addresses
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      left_ff.on <= 1'b0;
      right_ff.on <= 1'b0;
    end else if (hold_reset) begin
      left_ff.on <= 1'b0;
      right_ff.on <= 1'b0;
    end else begin
      if (wr_p2) begin
        left_ff.on <= reg_wdata[mpc_pkg::BIT_LEFT_ON_P2];
        right_ff.on <= reg_wdata[mpc_pkg::BIT_RIGHT_ON_P2];
      end
      if (wr_left) begin
        left_ff.on <= reg_wdata[mpc_pkg::BIT_CH_ON];
      end
      if (wr_right) begin
        right_ff.on <= reg_wdata[mpc_pkg::BIT_CH_ON];
      end
    end
  end

  // =====================================================================
  // gain register fields
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      left_ff.silence <= 1'b0;
      left_ff.zc_gate <= 1'b0;
      left_ff.pending_gain <= mpc_pkg::GAIN_RESET;
      right_ff.silence <= 1'b0;
      right_ff.zc_gate <= 1'b0;
      right_ff.pending_gain <= mpc_pkg::GAIN_RESET;
    end else if (hold_reset) begin
      left_ff.silence <= 1'b0;
      left_ff.zc_gate <= 1'b0;
      left_ff.pending_gain <= mpc_pkg::GAIN_RESET;
      right_ff.silence <= 1'b0;
      right_ff.zc_gate <= 1'b0;
      right_ff.pending_gain <= mpc_pkg::GAIN_RESET;
    end else begin
      if (wr_left) begin
        left_ff.silence <= reg_wdata[mpc_pkg::BIT_CH_SILENCE];
        left_ff.zc_gate <= reg_wdata[mpc_pkg::BIT_CH_ZC];
        left_ff.pending_gain <= reg_wdata[mpc_pkg::GAIN_LSB +: mpc_pkg::GAIN_W];
      end
      if (wr_right) begin
        right_ff.silence <= reg_wdata[mpc_pkg::BIT_CH_SILENCE];
        right_ff.zc_gate <= reg_wdata[mpc_pkg::BIT_CH_ZC];
        right_ff.pending_gain <= reg_wdata[mpc_pkg::GAIN_LSB +: mpc_pkg::GAIN_W];
      end
    end
  end

  // strobe bit is write-only in effect and reads back as zero
  assign gain_update_strobe = !hold_reset && (wr_left || wr_right)
                              && reg_wdata[mpc_pkg::BIT_UPDATE];

  // =====================================================================
  // pin selection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {left_second_pos_pin_connect_ff, left_neg_pin_connect_ff,
       left_first_pos_pin_connect_ff} <= mpc_pkg::PINS_RESET;
      {right_second_pos_pin_connect_ff, right_neg_pin_connect_ff,
       right_first_pos_pin_connect_ff} <= mpc_pkg::PINS_RESET;
    end else if (hold_reset) begin
      {left_second_pos_pin_connect_ff, left_neg_pin_connect_ff,
       left_first_pos_pin_connect_ff} <= mpc_pkg::PINS_RESET;
      {right_second_pos_pin_connect_ff, right_neg_pin_connect_ff,
       right_first_pos_pin_connect_ff} <= mpc_pkg::PINS_RESET;
    end else if (wr_pins) begin
      left_first_pos_pin_connect_ff <= reg_wdata[mpc_pkg::BIT_L_FIRST_POS];
      left_neg_pin_connect_ff <= reg_wdata[mpc_pkg::BIT_L_NEG];
      left_second_pos_pin_connect_ff <= reg_wdata[mpc_pkg::BIT_L_SECOND_POS];
      right_first_pos_pin_connect_ff <= reg_wdata[mpc_pkg::BIT_R_FIRST_POS];
      right_neg_pin_connect_ff <= reg_wdata[mpc_pkg::BIT_R_NEG];
      right_second_pos_pin_connect_ff <= reg_wdata[mpc_pkg::BIT_R_SECOND_POS];
    end
  end

  // =====================================================================
  // mic bias
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mic_bias_on_ff <= 1'b0;
      mic_bias_level_select_ff <= 1'b0;
    end else if (hold_reset) begin
      mic_bias_on_ff <= 1'b0;
      mic_bias_level_select_ff <= 1'b0;
    end else begin
      if (wr_p1) begin
        mic_bias_on_ff <= reg_wdata[mpc_pkg::BIT_BIAS_ON_P1];
      end
      if (wr_bias) begin
        mic_bias_on_ff <= reg_wdata[mpc_pkg::BIT_BIAS_ON];
        mic_bias_level_select_ff <= reg_wdata[mpc_pkg::BIT_BIAS_LEVEL];
      end
    end
  end

  // =====================================================================
  // gain apply, one per channel
  mpc_gain_apply u_left_apply (
    .mclk(mclk),
    .reset_n(reset_n),
    .hold_reset(hold_reset),
    .release_pulse(gain_update_strobe),
    .zc_gate(left_ff.zc_gate),
    .zero_cross(left_zero_cross),
    .pending_gain(left_ff.pending_gain),
    .gain_ff(left_gain),
    .waiting_ff(left_gain_waiting)
  );

  mpc_gain_apply u_right_apply (
    .mclk(mclk),
    .reset_n(reset_n),
    .hold_reset(hold_reset),
    .release_pulse(gain_update_strobe),
    .zc_gate(right_ff.zc_gate),
    .zero_cross(right_zero_cross),
    .pending_gain(right_ff.pending_gain),
    .gain_ff(right_gain),
    .waiting_ff(right_gain_waiting)
  );

  // =====================================================================
  // read back, data in the cycle after the strobe only
  always_comb begin
    nxt_rdata = mpc_pkg::ZERO16;
    case (reg_addr)
      mpc_pkg::ADDR_POWER_ONE: begin
        nxt_rdata[mpc_pkg::BIT_BIAS_ON_P1] = mic_bias_on_ff;
      end
      mpc_pkg::ADDR_POWER_TWO: begin
        nxt_rdata[mpc_pkg::BIT_LEFT_ON_P2] = left_ff.on;
        nxt_rdata[mpc_pkg::BIT_RIGHT_ON_P2] = right_ff.on;
      end
      mpc_pkg::ADDR_POWER_FIVE: begin
        nxt_rdata[mpc_pkg::BIT_MASTER_ON] = master_codec_on_ff;
      end
      mpc_pkg::ADDR_PIN_SELECT: begin
        nxt_rdata[mpc_pkg::BIT_L_FIRST_POS] = left_first_pos_pin_connect_ff;
        nxt_rdata[mpc_pkg::BIT_L_NEG] = left_neg_pin_connect_ff;
        nxt_rdata[mpc_pkg::BIT_L_SECOND_POS] = left_second_pos_pin_connect_ff;
        nxt_rdata[mpc_pkg::BIT_R_FIRST_POS] = right_first_pos_pin_connect_ff;
        nxt_rdata[mpc_pkg::BIT_R_NEG] = right_neg_pin_connect_ff;
        nxt_rdata[mpc_pkg::BIT_R_SECOND_POS] = right_second_pos_pin_connect_ff;
      end
      mpc_pkg::ADDR_BIAS_CONTROL: begin
        nxt_rdata[mpc_pkg::BIT_BIAS_ON] = mic_bias_on_ff;
        nxt_rdata[mpc_pkg::BIT_BIAS_LEVEL] = mic_bias_level_select_ff;
      end
      mpc_pkg::ADDR_LEFT_GAIN: begin
        nxt_rdata[mpc_pkg::BIT_CH_ON] = left_ff.on;
        nxt_rdata[mpc_pkg::BIT_CH_SILENCE] = left_ff.silence;
        nxt_rdata[mpc_pkg::BIT_CH_ZC] = left_ff.zc_gate;
        nxt_rdata[mpc_pkg::GAIN_LSB +: mpc_pkg::GAIN_W] = left_ff.pending_gain;
      end
      mpc_pkg::ADDR_RIGHT_GAIN: begin
        nxt_rdata[mpc_pkg::BIT_CH_ON] = right_ff.on;
        nxt_rdata[mpc_pkg::BIT_CH_SILENCE] = right_ff.silence;
        nxt_rdata[mpc_pkg::BIT_CH_ZC] = right_ff.zc_gate;
        nxt_rdata[mpc_pkg::GAIN_LSB +: mpc_pkg::GAIN_W] = right_ff.pending_gain;
      end
      default: begin
        nxt_rdata = mpc_pkg::ZERO16;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= mpc_pkg::ZERO16;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= mpc_pkg::ZERO16;
    end
  end

  assign reg_rdata = rdata_ff;

  // =====================================================================
  // analogue-facing outputs; one gain word drives every selected pin
  always_comb begin
    left_drive.on = left_ff.on;
    left_drive.silence = left_ff.silence;
    left_drive.first_pos_pin = left_first_pos_pin_connect_ff;
    left_drive.neg_pin = left_neg_pin_connect_ff;
    left_drive.second_pos_pin = left_second_pos_pin_connect_ff;
    left_drive.gain = left_gain;
    right_drive.on = right_ff.on;
    right_drive.silence = right_ff.silence;
    right_drive.first_pos_pin = right_first_pos_pin_connect_ff;
    right_drive.neg_pin = right_neg_pin_connect_ff;
    right_drive.second_pos_pin = right_second_pos_pin_connect_ff;
    right_drive.gain = right_gain;
  end

  // enable low drives the bias pin; high leaves it floating
  assign mic_bias_output_oe_n = !mic_bias_on_ff;
  assign mic_bias_level_select = mic_bias_level_select_ff;
  assign master_codec_on = master_codec_on_ff;

endmodule

// *** design/mpc_pkg.sv ***
// package: register map, field positions and reset values for the mic preamp controls
package mpc_pkg;

  // =====================================================================
  // register offsets (printed offsets are register indices)
  localparam logic [7:0] ADDR_POWER_ONE = 8'h08;
  localparam logic [7:0] ADDR_POWER_TWO = 8'h09;
  localparam logic [7:0] ADDR_POWER_FIVE = 8'h0c;
  localparam logic [7:0] ADDR_PIN_SELECT = 8'h48;
  localparam logic [7:0] ADDR_BIAS_CONTROL = 8'h4a;
  localparam logic [7:0] ADDR_LEFT_GAIN = 8'h50;
  localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h51;

  // =====================================================================
  // field positions
  localparam int BIT_MASTER_ON = 12;
  localparam int BIT_BIAS_ON_P1 = 4;
  localparam int BIT_LEFT_ON_P2 = 8;
  localparam int BIT_RIGHT_ON_P2 = 9;
  localparam int BIT_CH_ON = 15;
  localparam int BIT_CH_SILENCE = 14;
  localparam int BIT_CH_ZC = 13;
  localparam int BIT_UPDATE = 8;
  localparam int GAIN_LSB = 2;
  localparam int GAIN_W = 6;
  localparam int BIT_BIAS_ON = 15;
  localparam int BIT_BIAS_LEVEL = 14;
  localparam int BIT_L_FIRST_POS = 0;
  localparam int BIT_L_NEG = 1;
  localparam int BIT_L_SECOND_POS = 2;
  localparam int BIT_R_FIRST_POS = 8;
  localparam int BIT_R_NEG = 9;
  localparam int BIT_R_SECOND_POS = 10;

  // =====================================================================
  // reset values
  localparam logic [5:0] GAIN_RESET = 6'h10;
  localparam logic [2:0] PINS_RESET = 3'h3;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // one channel's control set
  typedef struct packed {
    logic on;
    logic silence;
    logic zc_gate;
    logic [5:0] pending_gain;
  } mpc_chan_t;

  // analogue-facing per-channel controls
  typedef struct packed {
    logic on;
    logic silence;
    logic first_pos_pin;
    logic neg_pin;
    logic second_pos_pin;
    logic [5:0] gain;
  } mpc_drive_t;

endpackage

// *** design/mpc_gain_apply.sv ***
// file: one channel's gain release and zero-cross gated apply
`timescale 1ns/100ps
module mpc_gain_apply (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hold_reset,
  input wire logic release_pulse,
  input wire logic zc_gate,
  input wire logic zero_cross,
  input wire logic [5:0] pending_gain,
  output logic [5:0] gain_ff,
  output logic waiting_ff
);

  // =====================================================================
  // zero crossing capture
  logic zero_cross_ff;
  logic [5:0] held_gain_ff;
  logic nxt_waiting;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zero_cross_ff <= 1'b0;
    end else begin
      zero_cross_ff <= zero_cross;
    end
  end

  // =====================================================================
  // apply
  always_comb begin
    nxt_waiting = waiting_ff;
    if (release_pulse) begin
      nxt_waiting = zc_gate;
    end else if (waiting_ff && (zero_cross_ff || !zc_gate)) begin
      nxt_waiting = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gain_ff <= mpc_pkg::GAIN_RESET;
      held_gain_ff <= mpc_pkg::GAIN_RESET;
      waiting_ff <= 1'b0;
    end else if (hold_reset) begin
      gain_ff <= mpc_pkg::GAIN_RESET;
      held_gain_ff <= mpc_pkg::GAIN_RESET;
      waiting_ff <= 1'b0;
    end else begin
      waiting_ff <= nxt_waiting;
      if (release_pulse) begin
        held_gain_ff <= pending_gain;
        if (!zc_gate) begin
          gain_ff <= pending_gain;
        end
      end else if (waiting_ff && (zero_cross_ff || !zc_gate)) begin
        // pending may be rewritten before the crossing, so the stored copy is used
        gain_ff <= held_gain_ff;
      end
    end
  end

endmodule

// *** verification/mpc_regs_sva.sv ***
// checker: port-level properties of the mic preamp register bank
`timescale 1ns/100ps
module mpc_regs_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic left_zero_cross,
  input wire logic right_zero_cross,
  input wire mpc_pkg::mpc_drive_t left_drive,
  input wire mpc_pkg::mpc_drive_t right_drive,
  input wire logic mic_bias_output_oe_n,
  input wire logic mic_bias_level_select,
  input wire logic master_codec_on,
  input wire logic left_gain_waiting,
  input wire logic right_gain_waiting
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ======================================================================
  // sequences
  sequence wr_at(logic [7:0] a);
    reg_wr && master_codec_on && reg_addr == a;
  endsequence
  sequence zc_left;
    left_gain_waiting && left_zero_cross;
  endsequence
  sequence zc_right;
    right_gain_waiting && right_zero_cross;
  endsequence
  // ======================================================================
  // properties
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  held_reset_a: assert property (!master_codec_on [*2] |->
    left_drive.gain == mpc_pkg::GAIN_RESET && !right_drive.on && mic_bias_output_oe_n)
    else $error("controls moved while master enable clear");
  pins_write_a: assert property (wr_at(mpc_pkg::ADDR_PIN_SELECT) |=>
    {left_drive.first_pos_pin, left_drive.neg_pin, left_drive.second_pos_pin}
    == {$past(reg_wdata[0]), $past(reg_wdata[1]), $past(reg_wdata[2])}
    && right_drive.second_pos_pin == $past(reg_wdata[10]))
    else $error("pin connect outputs do not follow write");
  chan_on_a: assert property (wr_at(mpc_pkg::ADDR_POWER_TWO) |=>
    left_drive.on == $past(reg_wdata[8]) && right_drive.on == $past(reg_wdata[9]))
    else $error("preamp enable does not follow power write");
  left_alias_a: assert property (wr_at(mpc_pkg::ADDR_LEFT_GAIN) |=>
    left_drive.on == $past(reg_wdata[15]) && left_drive.silence == $past(reg_wdata[14]))
    else $error("left enable or silence does not follow gain write");
  bias_one_a: assert property (wr_at(mpc_pkg::ADDR_POWER_ONE) |=>
    mic_bias_output_oe_n == !$past(reg_wdata[4]))
    else $error("bias drive does not follow power write");
  bias_ctl_a: assert property (wr_at(mpc_pkg::ADDR_BIAS_CONTROL) |=>
    mic_bias_output_oe_n == !$past(reg_wdata[15])
    && mic_bias_level_select == $past(reg_wdata[14]))
    else $error("bias controls do not follow bias write");
  gain_hold_a: assert property (reg_wr && !reg_wdata[8] && !left_gain_waiting
    && !right_gain_waiting && (reg_addr == 8'h50 || reg_addr == 8'h51)
    |=> $stable(left_drive.gain) && $stable(right_drive.gain))
    else $error("gain moved without update strobe");
  zc_left_a: assert property (zc_left |-> ##2 !left_gain_waiting)
    else $error("left gain still waiting after crossing");
  zc_right_a: assert property (zc_right |-> ##2 !right_gain_waiting)
    else $error("right gain still waiting after crossing");
endmodule

bind mpc_regs mpc_regs_sva u_mpc_regs_sva (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .left_zero_cross, .right_zero_cross, .left_drive, .right_drive,
  .mic_bias_output_oe_n, .mic_bias_level_select, .master_codec_on, .left_gain_waiting,
  .right_gain_waiting);

// *** verification/testbench.sv ***
// testbench: directed scenarios for the mic preamp register bank
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic left_zero_cross = 1'b0;
  logic right_zero_cross = 1'b0;
  mpc_pkg::mpc_drive_t left_drive;
  mpc_pkg::mpc_drive_t right_drive;
  logic mic_bias_output_oe_n;
  logic mic_bias_level_select;
  logic master_codec_on;
  logic left_gain_waiting;
  logic right_gain_waiting;
  int errors = 0;
  int total_checks = 0;

  always #25 mclk = ~mclk;

  mpc_regs u_mpc_regs (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .left_zero_cross, .right_zero_cross, .left_drive, .right_drive, .mic_bias_output_oe_n,
    .mic_bias_level_select, .master_codec_on, .left_gain_waiting, .right_gain_waiting);

  // ======================================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata);
  endtask
  // drive struct image: on, silence, pins first/neg/second, gain
  function automatic logic [15:0] dv(input logic on, input logic sil, input logic [2:0] p,
                                     input logic [5:0] g);
    return {5'h00, on, sil, p, g};
  endfunction
  task automatic zc_pulse(input logic left);
    @(posedge mclk);
    left_zero_cross <= left;
    right_zero_cross <= !left;
    @(posedge mclk);
    left_zero_cross <= 1'b0;
    right_zero_cross <= 1'b0;
    #1;
  endtask
  task automatic chk_w(input logic [1:0] exp);
    chk("waiting flags", {14'h0, exp}, {14'h0, left_gain_waiting, right_gain_waiting});
  endtask

  // ======================================================================
  // scenarios
  task automatic t_locked;
    chk("left drive", dv(0, 0, 3'h6, 6'h10), {5'h00, left_drive});
    chk("right drive", dv(0, 0, 3'h6, 6'h10), {5'h00, right_drive});
    chk("bias oe_n", 16'h0001, {15'h0, mic_bias_output_oe_n});
    wr(8'h50, 16'h8000);
    chk("left drive", dv(0, 0, 3'h6, 6'h10), {5'h00, left_drive});
    rd(8'h50, 16'h0040);
    wr(8'h0c, 16'h1000);
    chk("master", 16'h0001, {15'h0, master_codec_on});
    rd(8'h08, 16'h0000);
    rd(8'h09, 16'h0000);
    rd(8'h48, 16'h0303);
    rd(8'h4a, 16'h0000);
    rd(8'h51, 16'h0040);
    rd(8'h20, 16'h0000);
  endtask
  task automatic t_alias;
    wr(8'h09, 16'h0300);
    rd(8'h50, 16'h8040);
    rd(8'h51, 16'h8040);
    wr(8'h51, 16'h0040);
    rd(8'h09, 16'h0100);
    wr(8'h4a, 16'hc000);
    rd(8'h08, 16'h0010);
    chk("bias", 16'h0001, {14'h0, mic_bias_output_oe_n, mic_bias_level_select});
    wr(8'h08, 16'h0000);
    rd(8'h4a, 16'h4000);
    chk("bias oe_n", 16'h0001, {15'h0, mic_bias_output_oe_n});
  endtask
  task automatic t_pins_gain;
    wr(8'h48, 16'h0504);
    wr(8'h20, 16'hffff);
    rd(8'h48, 16'h0504);
    chk("left drive", dv(1, 0, 3'h1, 6'h10), {5'h00, left_drive});
    chk("right drive", dv(0, 0, 3'h5, 6'h10), {5'h00, right_drive});
    wr(8'h50, 16'h80fc);
    wr(8'h51, 16'h0000);
    chk("left gain", 16'h0010, {10'h0, left_drive.gain});
    rd(8'h50, 16'h80fc);
    wr(8'h51, 16'h0100);
    chk("left drive", dv(1, 0, 3'h1, 6'h3f), {5'h00, left_drive});
    chk("right drive", dv(0, 0, 3'h5, 6'h00), {5'h00, right_drive});
    rd(8'h51, 16'h0000);
    wr(8'h50, 16'hc0fc);
    chk("left drive", dv(1, 1, 3'h1, 6'h3f), {5'h00, left_drive});
  endtask
  task automatic t_zero_cross;
    wr(8'h50, 16'h2014);
    wr(8'h51, 16'h20a8);
    zc_pulse(1'b1);
    chk("left gain", 16'h003f, {10'h0, left_drive.gain});
    wr(8'h50, 16'h2114);
    chk_w(2'b11);
    repeat (3) @(posedge mclk);
    #1;
    chk_w(2'b11);
    chk("left gain", 16'h003f, {10'h0, left_drive.gain});
    zc_pulse(1'b1);
    chk("left gain", 16'h003f, {10'h0, left_drive.gain});
    @(posedge mclk);
    #1;
    chk("left gain", 16'h0005, {10'h0, left_drive.gain});
    chk_w(2'b01);
    zc_pulse(1'b0);
    @(posedge mclk);
    #1;
    chk("right gain", 16'h002a, {10'h0, right_drive.gain});
    chk_w(2'b00);
  endtask
  task automatic t_master_off;
    wr(8'h0c, 16'h0000);
    repeat (2) @(posedge mclk);
    #1;
    chk("left drive", dv(0, 0, 3'h6, 6'h10), {5'h00, left_drive});
    rd(8'h48, 16'h0303);
  endtask

  // ======================================================================
  // run control
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge mclk);
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_locked;
    t_alias;
    t_pins_gain;
    t_zero_cross;
    t_master_off;
    report_and_stop;
  end
endmodule
